// >>> sbde_consts.vh
// constants for the secure boot digest engine
`ifndef SBDE_CONSTS_VH
`define SBDE_CONSTS_VH
// operation modes on op_mode
`define SBDE_MODE_RNG 2'h0
`define SBDE_MODE_DIGEST 2'h1
`define SBDE_MODE_CMP 2'h2
// stream geometry in 32-bit words
`define SBDE_IV_WORDS 6'h20
`define SBDE_HASH_WORDS 6'h10
`define SBDE_BLK_LAST 2'h3
// image padding: 128-byte alignment, pad byte value
`define SBDE_ALIGN_ADD 17'h0007F
`define SBDE_ALIGN_MASK 17'h1FF80
`define SBDE_PAD_BYTE 8'hFF
`define SBDE_PAD_WORD 32'hFFFFFFFF
`endif

// >>> sbde_engine.v
// secure boot digest engine: random bytes, keyed image digest, digest compare
`timescale 1ns/10ps
`default_nettype none
`include "sbde_consts.vh"
// What this block does
// - a random mode streams words taken from the hardware random source to the output.
// - the digest is computed with the key held in fuse block 2.
// - a computed digest is only presented on the output if the synchronised done fuse reads 0 when the hash completes.
// - compare mode recomputes the digest and reports only match or mismatch.
// - compare mode works whatever the state of the done fuse.
// - a 128-byte random IV is placed in front of the image.
// - the image is padded with 0xFF up to the next 128-byte boundary.
// - each 16-byte plaintext block is byte-reversed before encryption.
// - each block is encrypted alone with a 256-bit key, no chaining.
// - each cipher block is byte-reversed and appended in order.
// - every 4-byte word of the ciphertext is byte-swapped.
// - the swapped ciphertext is hashed with SHA-512.
// - the digest is 192 bytes: the 128-byte IV then the 64-byte hash.
// - the raw 32-byte secret key is the encryption key.
module sbde_engine (
    input wire mclk,
    input wire sys_rst,
    input wire op_start,
    input wire [1:0] op_mode,
    input wire [15:0] op_len,
    output reg busy_reg,
    output reg done_reg,
    output reg match_reg,
    input wire secure_boot_done_fuse,
    input wire [255:0] fuse_key,
    input wire trng_valid,
    input wire [31:0] trng_data,
    input wire in_valid,
    input wire [31:0] in_data,
    output reg in_ready_reg,
    output reg out_valid_reg,
    output reg [31:0] out_data_reg,
    input wire out_ready,
    output reg aes_req_reg,
    output reg [255:0] aes_key_reg,
    output reg [127:0] aes_blk_reg,
    input wire aes_done,
    input wire [127:0] aes_res,
    output reg sha_init_reg,
    output reg sha_valid_reg,
    output reg [31:0] sha_data_reg,
    output reg sha_last_reg,
    input wire sha_ready,
    input wire sha_done,
    input wire [511:0] sha_hash
);
    // ----------------------------------------
    // states and helpers
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_RNG = 4'h1;
    localparam [3:0] ST_IVGEN = 4'h2;
    localparam [3:0] ST_IVREF = 4'h3;
    localparam [3:0] ST_GATHER = 4'h4;
    localparam [3:0] ST_AES = 4'h5;
    localparam [3:0] ST_SHA = 4'h6;
    localparam [3:0] ST_HWAIT = 4'h7;
    localparam [3:0] ST_OUTIV = 4'h8;
    localparam [3:0] ST_OUTH = 4'h9;
    localparam [3:0] ST_CMP = 4'hA;
    localparam [3:0] ST_FIN = 4'hB;

    // swap the bytes of one word
    function [31:0] bswap32;
        input [31:0] w;
        begin
            bswap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
    endfunction

    // reverse the 16 bytes of a block
    function [127:0] brev128;
        input [127:0] b;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1)
            begin
                brev128[i*8 +: 8] = b[(15-i)*8 +: 8];
            end
        end
    endfunction

    // word k of the hash in memory byte order
    function [31:0] hash_word;
        input [511:0] h;
        input [3:0] k;
        begin
            hash_word = bswap32(h[511 - k*32 -: 32]);
        end
    endfunction

    reg [3:0] state_reg;
    reg [1:0] mode_reg;
    reg [5:0] idx_reg;
    reg [1:0] wcnt_reg;
    reg [16:0] words_left_reg;
    reg [16:0] img_rem_reg;
    reg [15:0] rng_left_reg;
    reg [127:0] blk_reg;
    reg [127:0] ct_reg;
    reg [511:0] hash_reg;
    reg mis_reg;
    reg [31:0] iv_mem [0:31];
    reg fuse_meta_reg;
    reg fuse_sync_reg;
    reg [31:0] buf_tail_reg;
    reg [1:0] buf_cnt_reg;
    reg push;
    reg [31:0] push_data;
    reg [31:0] img_word;
    integer b;
    wire [16:0] pad_len;
    wire in_take;
    wire pop;
    wire can_push;

    // image length rounded up to the 128-byte boundary
    assign pad_len = ({1'b0, op_len} + `SBDE_ALIGN_ADD) & `SBDE_ALIGN_MASK;
    assign in_take = in_valid && in_ready_reg;
    assign pop = out_valid_reg && out_ready;
    assign can_push = (buf_cnt_reg != 2'h2);

    // ----------------------------------------
    // fuse pin synchroniser
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            fuse_meta_reg <= 1'b1;
            fuse_sync_reg <= 1'b1;
        end
        else
        begin
            fuse_meta_reg <= secure_boot_done_fuse;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // ----------------------------------------
    // producer side of the output buffer
    // ----------------------------------------
    always @*
    begin
        push = 1'b0;
        push_data = 32'h00000000;
        case (state_reg)
            ST_RNG:
            begin
                push = trng_valid && can_push && (rng_left_reg != 16'h0000);
                push_data = trng_data;
            end
            ST_OUTIV:
            begin
                push = can_push;
                push_data = iv_mem[idx_reg[4:0]];
            end
            ST_OUTH:
            begin
                push = can_push;
                push_data = hash_word(hash_reg, idx_reg[3:0]);
            end
            default:
            begin
                push = 1'b0;
            end
        endcase
    end

    // image word with bytes past the end forced to the pad value
    always @*
    begin
        img_word = in_data;
        for (b = 0; b < 4; b = b + 1)
        begin
            if (img_rem_reg <= b)
            begin
                img_word[b*8 +: 8] = `SBDE_PAD_BYTE;
            end
        end
    end

    // ----------------------------------------
    // two-entry output buffer, head drives the port
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            buf_cnt_reg <= 2'h0;
            out_valid_reg <= 1'b0;
            out_data_reg <= 32'h00000000;
            buf_tail_reg <= 32'h00000000;
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (buf_cnt_reg == 2'h0)
                        out_data_reg <= push_data;
                    else
                        buf_tail_reg <= push_data;
                    buf_cnt_reg <= buf_cnt_reg + 2'h1;
                    out_valid_reg <= 1'b1;
                end
                2'b01:
                begin
                    out_data_reg <= buf_tail_reg;
                    buf_cnt_reg <= buf_cnt_reg - 2'h1;
                    out_valid_reg <= (buf_cnt_reg == 2'h2);
                end
                2'b11:
                begin
                    out_data_reg <= push_data; // only reachable with one entry held
                end
                default:
                begin
                    out_valid_reg <= (buf_cnt_reg != 2'h0);
                end
            endcase
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            mode_reg <= `SBDE_MODE_RNG;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            match_reg <= 1'b0;
            in_ready_reg <= 1'b0;
            aes_req_reg <= 1'b0;
            aes_key_reg <= 256'h0;
            aes_blk_reg <= 128'h0;
            sha_init_reg <= 1'b0;
            sha_valid_reg <= 1'b0;
            sha_data_reg <= 32'h00000000;
            sha_last_reg <= 1'b0;
            idx_reg <= 6'h00;
            wcnt_reg <= 2'h0;
            words_left_reg <= 17'h0;
            img_rem_reg <= 17'h0;
            rng_left_reg <= 16'h0000;
            blk_reg <= 128'h0;
            ct_reg <= 128'h0;
            hash_reg <= 512'h0;
            mis_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            sha_init_reg <= 1'b0;
            in_ready_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (op_start)
                    begin
                        busy_reg <= 1'b1;
                        match_reg <= 1'b0;
                        mis_reg <= 1'b0;
                        mode_reg <= op_mode;
                        idx_reg <= 6'h00;
                        wcnt_reg <= 2'h0;
                        rng_left_reg <= op_len;
                        img_rem_reg <= {1'b0, op_len};
                        words_left_reg <= {11'h000, `SBDE_IV_WORDS} + {2'b00, pad_len[16:2]};
                        aes_key_reg <= fuse_key;
                        if (op_mode == `SBDE_MODE_DIGEST)
                        begin
                            sha_init_reg <= 1'b1;
                            state_reg <= ST_IVGEN;
                        end
                        else if (op_mode == `SBDE_MODE_CMP)
                        begin
                            sha_init_reg <= 1'b1;
                            state_reg <= ST_IVREF;
                        end
                        else
                            state_reg <= ST_RNG;
                    end
                end
                ST_RNG:
                begin
                    if (push)
                        rng_left_reg <= rng_left_reg - 16'h0001;
                    else if (rng_left_reg == 16'h0000 && buf_cnt_reg == 2'h0)
                        state_reg <= ST_FIN;
                end
                ST_IVGEN:
                begin
                    if (trng_valid)
                    begin
                        iv_mem[idx_reg[4:0]] <= trng_data;
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == `SBDE_IV_WORDS - 6'h01)
                        begin
                            idx_reg <= 6'h00;
                            state_reg <= ST_GATHER;
                        end
                    end
                end
                ST_IVREF:
                begin
                    in_ready_reg <= !in_take && (idx_reg != `SBDE_IV_WORDS - 6'h01);
                    if (in_take) // the reference IV seeds the recompute
                    begin
                        iv_mem[idx_reg[4:0]] <= in_data;
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == `SBDE_IV_WORDS - 6'h01)
                        begin
                            idx_reg <= 6'h00;
                            state_reg <= ST_GATHER;
                        end
                    end
                    else
                        in_ready_reg <= 1'b1;
                end
                ST_GATHER:
                begin
                    // IV words first, then image words, then pure pad words
                    if (idx_reg != `SBDE_IV_WORDS)
                    begin
                        blk_reg <= {blk_reg[95:0], bswap32(iv_mem[idx_reg[4:0]])};
                        idx_reg <= idx_reg + 6'h01;
                        wcnt_reg <= wcnt_reg + 2'h1;
                        words_left_reg <= words_left_reg - 17'h1;
                    end
                    else if (img_rem_reg == 17'h0)
                    begin
                        blk_reg <= {blk_reg[95:0], `SBDE_PAD_WORD};
                        wcnt_reg <= wcnt_reg + 2'h1;
                        words_left_reg <= words_left_reg - 17'h1;
                    end
                    else if (in_take)
                    begin
                        blk_reg <= {blk_reg[95:0], bswap32(img_word)};
                        wcnt_reg <= wcnt_reg + 2'h1;
                        words_left_reg <= words_left_reg - 17'h1;
                        img_rem_reg <= (img_rem_reg > 17'h4) ? img_rem_reg - 17'h4 : 17'h0;
                    end
                    else
                        in_ready_reg <= 1'b1;
                    if (wcnt_reg == `SBDE_BLK_LAST && (idx_reg != `SBDE_IV_WORDS
                        || img_rem_reg == 17'h0 || in_take))
                        state_reg <= ST_AES;
                end
                ST_AES:
                begin
                    // one block at a time, nothing carried between blocks
                    aes_req_reg <= !aes_done;
                    aes_blk_reg <= brev128(blk_reg);
                    if (aes_done)
                    begin
                        ct_reg <= brev128(aes_res);
                        sha_valid_reg <= 1'b1;
                        sha_data_reg <= bswap32({aes_res[7:0], aes_res[15:8],
                            aes_res[23:16], aes_res[31:24]});
                        sha_last_reg <= 1'b0;
                        wcnt_reg <= 2'h0;
                        state_reg <= ST_SHA;
                    end
                end
                ST_SHA:
                begin
                    if (sha_ready)
                    begin
                        wcnt_reg <= wcnt_reg + 2'h1;
                        if (wcnt_reg == `SBDE_BLK_LAST)
                        begin
                            sha_valid_reg <= 1'b0;
                            sha_last_reg <= 1'b0;
                            state_reg <= (words_left_reg == 17'h0) ? ST_HWAIT : ST_GATHER;
                        end
                        else
                        begin
                            sha_data_reg <= bswap32(ct_reg[95 - wcnt_reg*32 -: 32]);
                            sha_last_reg <= (wcnt_reg == 2'h2) && (words_left_reg == 17'h0);
                        end
                    end
                end
                ST_HWAIT:
                begin
                    if (sha_done)
                    begin
                        hash_reg <= sha_hash;
                        idx_reg <= 6'h00;
                        if (mode_reg == `SBDE_MODE_CMP)
                            state_reg <= ST_CMP;
                        else if (!fuse_sync_reg)
                            state_reg <= ST_OUTIV;
                        else
                            state_reg <= ST_FIN;
                    end
                end
                ST_OUTIV:
                begin
                    if (push)
                    begin
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == `SBDE_IV_WORDS - 6'h01)
                        begin
                            idx_reg <= 6'h00;
                            state_reg <= ST_OUTH;
                        end
                    end
                end
                ST_OUTH:
                begin
                    if (push)
                    begin
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == `SBDE_HASH_WORDS - 6'h01)
                            state_reg <= ST_FIN;
                    end
                end
                ST_CMP:
                begin
                    in_ready_reg <= !in_take && (idx_reg != `SBDE_HASH_WORDS - 6'h01);
                    if (in_take) // only the verdict leaves the block
                    begin
                        if (in_data != hash_word(hash_reg, idx_reg[3:0]))
                            mis_reg <= 1'b1;
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == `SBDE_HASH_WORDS - 6'h01)
                            state_reg <= ST_FIN;
                    end
                    else
                        in_ready_reg <= 1'b1;
                end
                ST_FIN:
                begin
                    if (buf_cnt_reg == 2'h0)
                    begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        match_reg <= (mode_reg == `SBDE_MODE_CMP) && !mis_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // sbde_engine
`default_nettype wire

// >>> sbde_engine_chk.sv
// port checker for the secure boot digest engine
`timescale 1ns/10ps
`default_nettype none
module sbde_engine_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic op_start,
    input wire logic busy_reg,
    input wire logic done_reg,
    input wire logic match_reg,
    input wire logic in_valid,
    input wire logic in_ready_reg,
    input wire logic out_valid_reg,
    input wire logic [31:0] out_data_reg,
    input wire logic out_ready,
    input wire logic aes_req_reg,
    input wire logic [255:0] aes_key_reg,
    input wire logic [127:0] aes_blk_reg,
    input wire logic aes_done,
    input wire logic sha_init_reg,
    input wire logic sha_valid_reg,
    input wire logic [31:0] sha_data_reg,
    input wire logic sha_last_reg,
    input wire logic sha_ready
);
    // ----------------------------------------
    // operation, stream and core handshakes
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_done_single: assert property (done_reg |=> !done_reg)
        else $error("done pulse longer than one cycle");
    a_start_busy: assert property (op_start && !busy_reg |=> busy_reg)
        else $error("start in idle did not raise busy");
    a_done_idle: assert property (done_reg |=> !busy_reg)
        else $error("busy still high after done");
    a_aes_hold: assert property (aes_req_reg && !aes_done |=>
        aes_req_reg && $stable(aes_blk_reg) && $stable(aes_key_reg))
        else $error("aes request dropped or changed early");
    a_sha_hold: assert property (sha_valid_reg && !sha_ready |=>
        sha_valid_reg && $stable(sha_data_reg) && $stable(sha_last_reg))
        else $error("hash word dropped or changed early");
    a_out_hold: assert property (out_valid_reg && !out_ready |=>
        out_valid_reg && $stable(out_data_reg))
        else $error("output word lost under stall");
    a_in_gap: assert property (in_valid && in_ready_reg |=> !in_ready_reg)
        else $error("input ready did not drop after a take");
    a_match_done: assert property ($rose(match_reg) |-> done_reg)
        else $error("match rose outside done");
    a_init_pulse: assert property (sha_init_reg |=> !sha_init_reg)
        else $error("hash init longer than one cycle");
    // main scenarios reached
    c_match: cover property (done_reg && match_reg);
    c_stall: cover property (out_valid_reg && !out_ready);
    c_aes: cover property (aes_req_reg && aes_done);
endmodule // sbde_engine_chk
bind sbde_engine sbde_engine_chk chk (.*);
`default_nettype wire

// >>> sbde_core_model.sv
// behavioural stand-in for the cipher and hash cores
`timescale 1ns/10ps
`default_nettype none
module sbde_core_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic aes_req_reg,
    input wire logic [255:0] aes_key_reg,
    input wire logic [127:0] aes_blk_reg,
    output logic aes_done,
    output logic [127:0] aes_res,
    input wire logic sha_init_reg,
    input wire logic sha_valid_reg,
    input wire logic [31:0] sha_data_reg,
    input wire logic sha_last_reg,
    output logic sha_ready,
    output logic sha_done,
    output logic [511:0] sha_hash
);
    // ----------------------------------------
    // cores
    // ----------------------------------------
    reg [3:0] cnt;
    reg busy;
    reg fin;
    reg [127:0] res_q;
    reg [511:0] acc;
    // one block per request, no chaining; slow mode stretches latency
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            aes_done <= 1'b0;
            sha_done <= 1'b0;
            sha_ready <= 1'b0;
            fin <= 1'b0;
            acc <= 512'h0;
        end
        else
        begin
            aes_done <= 1'b0;
            if (!busy && aes_req_reg && !aes_done)
            begin
                busy <= 1'b1;
                cnt <= slow ? 4'h7 : 4'h0;
            end
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                aes_done <= 1'b1;
                res_q <= aes_blk_reg ^ aes_key_reg[255:128] ^ aes_key_reg[127:0];
            end
            sha_ready <= slow ? ~sha_ready : 1'b1;
            sha_done <= fin;
            fin <= 1'b0;
            if (sha_init_reg)
                acc <= 512'h0;
            else if (sha_valid_reg && sha_ready)
            begin
                acc <= {acc[479:0], acc[511:480] ^ sha_data_reg};
                fin <= sha_last_reg;
            end
        end
    end
    // results are only meaningful in the done cycle
    assign aes_res = aes_done ? res_q : ~res_q;
    assign sha_hash = sha_done ? acc : ~acc;
endmodule // sbde_core_model
`default_nettype wire

// >>> tb_sbde_engine.sv
// self-checking bench for the secure boot digest engine
`timescale 1ns/10ps
`default_nettype none
`include "sbde_consts.vh"
module tb_sbde_engine;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    reg mclk = 0;
    reg sys_rst = 1;
    reg op_start = 0;
    reg [1:0] op_mode = 0;
    reg [15:0] op_len = 0;
    reg secure_boot_done_fuse = 0;
    reg [255:0] fuse_key = {128'h0123456789ABCDEF0F1E2D3C4B5A6978, 128'h8796A5B4C3D2E1F013579BDF2468ACE0};
    reg trng_valid = 0;
    reg [31:0] trng_data = 32'h10000001;
    reg in_valid = 0;
    reg [31:0] in_data = 0;
    reg out_ready = 1;
    reg slow = 0;
    reg stall = 0;
    wire busy_reg, done_reg, match_reg, in_ready_reg, out_valid_reg;
    wire aes_req_reg, aes_done, sha_init_reg, sha_valid_reg, sha_last_reg, sha_ready, sha_done;
    wire [31:0] out_data_reg;
    wire [31:0] sha_data_reg;
    wire [255:0] aes_key_reg;
    wire [127:0] aes_blk_reg;
    wire [127:0] aes_res;
    wire [511:0] sha_hash;
    integer err_total = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer ip = 0;
    integer nin = 0;
    integer ndone = 0;
    integer lastcnt = 0;
    integer i;
    reg [31:0] inbuf [0:63];
    reg [31:0] dig [0:47];
    reg [511:0] hash_seen;
    reg [31:0] outq [$];
    reg [127:0] blkq [$];
    reg [127:0] resq [$];
    reg [31:0] shaq [$];
    sbde_engine dut (.*);
    sbde_core_model cores (.*);
    // clock
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    // random source, input feeder, stall pattern and monitors
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        trng_valid <= (cyc % 4 == 3);
        if (cyc % 4 == 3)
            trng_data <= trng_data + 32'h01010101;
        out_ready <= !stall || cyc[0];
        if (in_valid && in_ready_reg)
            ip = ip + 1;
        in_valid <= (ip < nin);
        in_data <= inbuf[ip];
        if (!sys_rst)
        begin
            if (done_reg)
                ndone = ndone + 1;
            if (out_valid_reg && out_ready)
                outq.push_back(out_data_reg);
            if (aes_done)
            begin
                blkq.push_back(aes_blk_reg);
                resq.push_back(aes_res);
                check(aes_key_reg, fuse_key);
            end
            if (sha_valid_reg && sha_ready)
                shaq.push_back(sha_data_reg);
            if (sha_valid_reg && sha_ready && sha_last_reg)
                lastcnt = shaq.size();
            if (sha_done)
                hash_seen = sha_hash;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task check(input [511:0] got, input [511:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    end
    endtask
    // hash word k as memory bytes, lowest byte first
    function [31:0] hword(input integer k);
        integer b;
    begin
        for (b = 0; b < 4; b = b + 1)
            hword[8*b +: 8] = hash_seen[511 - 8*(4*k+b) -: 8];
    end
    endfunction
    // start one operation, optionally poke a refused start, wait for done
    task run_op(input [1:0] m, input [15:0] len, input poke);
        integer n;
    begin
        outq.delete();
        blkq.delete();
        resq.delete();
        shaq.delete();
        ndone = 0;
        ip = 0;
        n = 0;
        @(posedge mclk);
        op_mode <= m;
        op_len <= len;
        op_start <= 1'b1;
        @(posedge mclk);
        op_start <= 1'b0;
        if (poke)
        begin
            repeat (3) @(posedge mclk);
            op_mode <= `SBDE_MODE_DIGEST;
            op_start <= 1'b1;
            @(posedge mclk);
            op_start <= 1'b0;
        end
        while (!done_reg && n < 20000)
        begin
            @(posedge mclk);
            n = n + 1;
        end
        check(n < 20000, 1);
        @(posedge mclk);
    end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_rng;
    begin
        run_op(`SBDE_MODE_RNG, 16'h0008, 1);
        check(outq.size(), 8);
        check(ndone, 1);
        for (i = 1; i < 8; i = i + 1)
            check(outq[i] - outq[i-1], 32'h01010101);
        check(match_reg, 0);
        $display("test rng finished");
    end
    endtask
    task t_digest;
    begin
        slow <= 1'b1;
        stall <= 1'b1;
        inbuf[0] = 32'h44332211;
        inbuf[1] = 32'hA5A56655;
        nin = 2;
        lastcnt = 0;
        run_op(`SBDE_MODE_DIGEST, 16'h0006, 0);
        check(outq.size(), 48);
        check(blkq.size(), 16);
        check(lastcnt, 64);
        for (i = 1; i < 32; i = i + 1)
            check(outq[i] - outq[i-1], 32'h01010101);
        check(blkq[0], {outq[3], outq[2], outq[1], outq[0]});
        check(blkq[8], {64'hFFFFFFFFFFFFFFFF, 64'hFFFF665544332211});
        check(blkq[15], {4{`SBDE_PAD_WORD}});
        for (i = 0; i < 64; i = i + 1)
            check(shaq[i], resq[i/4][32*(i%4) +: 32]);
        for (i = 0; i < 16; i = i + 1)
            check(outq[32+i], hword(i));
        for (i = 0; i < 48; i = i + 1)
            dig[i] = outq[i];
        stall <= 1'b0;
        slow <= 1'b0;
        $display("test digest finished");
    end
    endtask
    task t_cmp(input bad);
    begin
        secure_boot_done_fuse <= 1'b1;
        for (i = 0; i < 32; i = i + 1)
            inbuf[i] = dig[i];
        inbuf[32] = 32'h44332211;
        inbuf[33] = 32'hA5A56655;
        for (i = 0; i < 16; i = i + 1)
            inbuf[34+i] = dig[32+i];
        inbuf[40] = inbuf[40] ^ {31'h0, bad};
        nin = 50;
        run_op(`SBDE_MODE_CMP, 16'h0006, 0);
        check(match_reg, !bad);
        check(outq.size(), 0);
        $display("test compare finished");
    end
    endtask
    task t_locked;
    begin
        inbuf[0] = 32'h44332211;
        inbuf[1] = 32'hA5A56655;
        nin = 2;
        run_op(`SBDE_MODE_DIGEST, 16'h0006, 0);
        check(outq.size(), 0);
        check(ndone, 1);
        $display("test locked readback finished");
    end
    endtask
    task summarize;
    begin
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_rng;
        t_digest;
        t_cmp(1'b0);
        t_cmp(1'b1);
        t_locked;
        summarize;
    end
    // watchdog
    initial
    begin
        repeat (40000) @(posedge mclk);
        err_total = err_total + 1;
        summarize;
    end
endmodule // tb_sbde_engine
`default_nettype wire
